// ==== dbsi_pkg.sv ====
// package of constants and types for the double-data-rate burst sram block
// Summary of operation
// R1 - read_output_valid marks when valid read data sits on the data bus
// R2 - read_output_valid changes on the same edges as both echo strobes
// R3 - accesses begin only on a rising edge of the true input clock
// R4 - true clock rising edge samples inputs and launches read data
// R5 - complementary clock rising edge samples write data and launches read data
// R6 - two free-running echo strobes follow the true and complementary clocks
// R7 - pll_disable_n low selects the legacy one-cycle-latency mode
// R8 - in legacy mode the controller keeps input clocks at or below 167 MHz
// R9 - pll_disable_n high: read data returns 2.5 cycles after the command edge
// R10 - pll_disable_n low: read data returns one cycle after the command
// R11 - write words are registered on both true and complementary rising edges
// R12 - read words leave through registers on both clock rising edges
// R13 - load, direction and lane selects are registered on the true rising edge; the code takes the second word's lane selects on the complementary edge
// R14 - cycle_load_n low starts a bus cycle moving a burst of two words
// R15 - with load low, direction high requests a read, low a write
// R16 - a deasserted lane select leaves its nine-bit byte unchanged
// R17 - data outputs float whenever no read burst is being driven
// R18 - read_output_valid rises half a cycle early and holds through the burst
package dbsi_pkg;

  localparam int unsigned DBSI_LANE_W  = 9;
  localparam int unsigned DBSI_LANES   = 2;
  localparam int unsigned DBSI_DATA_W  = DBSI_LANE_W * DBSI_LANES;
  localparam int unsigned DBSI_ADDR_W  = 4;
  localparam int unsigned DBSI_BURST   = 2;
  localparam int unsigned DBSI_DEPTH   = 1 << DBSI_ADDR_W;
  localparam int unsigned DBSI_FIFO_DEPTH = 4;
  // write log record: address, two words, two lane masks
  localparam int unsigned DBSI_LOG_W   =
    DBSI_ADDR_W + DBSI_BURST * (DBSI_DATA_W + DBSI_LANES);

  localparam logic [DBSI_DATA_W-1:0] DBSI_WORD_RESET = 18'h00000;
  localparam logic [DBSI_LANES-1:0]  DBSI_LANES_OFF  = 2'h3;

  typedef logic [DBSI_DATA_W-1:0] dbsi_word_type;
  typedef logic [DBSI_ADDR_W-1:0] dbsi_addr_type;
  typedef logic [DBSI_LANES-1:0]  dbsi_lane_type;

endpackage

// ==== dbsi_fifo.sv ====
// dual-clock fifo with gray-coded pointers, valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dbsi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             wr_clk,
  input  wire logic             wr_rst_n,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_clk,
  input  wire logic             rd_rst_n,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin;
  logic [AW:0]      wgray;
  logic [AW:0]      rbin;
  logic [AW:0]      rgray;
  logic [AW:0]      rgray_s1;
  logic [AW:0]      rgray_s2;
  logic [AW:0]      wgray_s1;
  logic [AW:0]      wgray_s2;
  logic [AW:0]      next_wbin;
  logic [AW:0]      next_rbin;
  logic             push;
  logic             pop;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // full when write gray equals read gray with top two bits inverted
  always_comb begin
    wr_ready  = (wgray != {~rgray_s2[AW:AW-1], rgray_s2[AW-2:0]});
    push      = wr_valid && wr_ready;
    next_wbin = push ? wbin + 1'b1 : wbin;
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin     <= '0;
      wgray    <= '0;
      rgray_s1 <= '0;
      rgray_s2 <= '0;
    end else begin
      wbin     <= next_wbin;
      wgray    <= to_gray(next_wbin);
      rgray_s1 <= rgray;
      rgray_s2 <= rgray_s1;
    end
  end

  // storage carries no reset; only written entries are ever read
  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin[AW-1:0]] <= wr_data;
    end
  end

  always_comb begin
    rd_valid  = (rgray != wgray_s2);
    pop       = rd_valid && rd_ready;
    next_rbin = pop ? rbin + 1'b1 : rbin;
    rd_data   = mem[rbin[AW-1:0]];
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin     <= '0;
      rgray    <= '0;
      wgray_s1 <= '0;
      wgray_s2 <= '0;
    end else begin
      rbin     <= next_rbin;
      rgray    <= to_gray(next_rbin);
      wgray_s1 <= wgray;
      wgray_s2 <= wgray_s1;
    end
  end

endmodule
`default_nettype wire

// ==== dbsi_core.sv ====
// device side of the double-data-rate two-word burst sram interface
`timescale 1ns/1ps
`default_nettype none
module dbsi_core
  import dbsi_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          link_clk,
  input  wire logic          cycle_load_n,
  input  wire logic          read_not_write,
  input  wire dbsi_addr_type addr,
  input  wire dbsi_lane_type byte_lane_select_n,
  input  wire dbsi_word_type dq_in,
  output logic               dq_out_word_valid_unused_n,
  output dbsi_word_type      dq_out,
  output logic               dq_oe,
  output logic               read_output_valid,
  output logic               echo_strobe_true,
  output logic               echo_strobe_comp,
  input  wire logic          pll_disable_n,
  output logic               wlog_space,
  output logic               wlog_valid,
  input  wire logic          wlog_ready,
  output dbsi_addr_type      wlog_addr,
  output dbsi_word_type      wlog_word0,
  output dbsi_word_type      wlog_word1,
  output dbsi_lane_type      wlog_lanes_n0,
  output dbsi_lane_type      wlog_lanes_n1
);
  // the complementary input clock rises when link_clk falls, so the
  // complementary-edge logic runs on the falling edge of link_clk

  // ---------------- link-domain reset ----------------
  logic link_rst_s1;
  logic link_rst_n;

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      link_rst_s1 <= 1'b0;
      link_rst_n  <= 1'b0;
    end else begin
      link_rst_s1 <= 1'b1;
      link_rst_n  <= link_rst_s1;
    end
  end

  // merges a word into a stored word lane by lane
  function automatic dbsi_word_type lane_merge(input dbsi_word_type old_w,
                                               input dbsi_word_type new_w,
                                               input dbsi_lane_type sel_n);
    dbsi_word_type w;
    w = old_w;
    for (int i = 0; i < DBSI_LANES; i++) begin
      if (!sel_n[i]) begin
        w[i*DBSI_LANE_W +: DBSI_LANE_W] = new_w[i*DBSI_LANE_W +: DBSI_LANE_W];
      end
    end
    lane_merge = w;
  endfunction

  // ---------------- storage ----------------
  dbsi_word_type arr0 [DBSI_DEPTH];
  dbsi_word_type arr1 [DBSI_DEPTH];

  // ---------------- true-edge state ----------------
  logic          pll_s1;
  logic          pll_on;
  logic          phase_p;
  logic          rd_s1;
  logic          rd_s2;
  logic          rd_s3;
  logic          wr_s1;
  logic          wr_s2;
  dbsi_addr_type addr_s1;
  dbsi_addr_type waddr_s2;
  dbsi_word_type w0_s2;
  dbsi_word_type w1_s2;
  dbsi_word_type w0_s3;
  dbsi_word_type w1_s3;
  dbsi_word_type wd0;
  dbsi_lane_type bws0;
  dbsi_word_type q_pos;
  logic          oe_pos;
  logic          vld_pos;
  logic          space_ff;

  logic          next_rd_s1;
  logic          next_wr_s1;
  logic          next_rd_s2;
  logic          next_rd_s3;
  logic          next_wr_s2;
  dbsi_addr_type next_addr_s1;
  dbsi_addr_type next_waddr_s2;
  dbsi_word_type next_w0_s2;
  dbsi_word_type next_w1_s2;
  dbsi_word_type next_w0_s3;
  dbsi_word_type next_w1_s3;
  dbsi_word_type next_wd0;
  dbsi_lane_type next_bws0;
  dbsi_word_type next_q_pos;
  logic          next_oe_pos;
  logic          next_vld_pos;

  // ---------------- complementary-edge state ----------------
  logic          phase_n;
  dbsi_word_type q_neg;
  logic          oe_neg;
  logic          vld_neg;
  logic          commit;
  dbsi_addr_type c_addr;
  dbsi_word_type c_w0;
  dbsi_word_type c_w1;
  dbsi_lane_type c_l0;
  dbsi_lane_type c_l1;

  dbsi_word_type next_q_neg;
  logic          next_oe_neg;
  logic          next_vld_neg;

  logic          fifo_ready;
  logic          fifo_valid;
  logic [DBSI_LOG_W-1:0] fifo_in;
  logic [DBSI_LOG_W-1:0] fifo_out;

  // commands are taken only here, on the true rising edge [R3] [R13] [R14]
  always_comb begin
    next_rd_s1   = !cycle_load_n && read_not_write;  // [R15]
    next_wr_s1   = !cycle_load_n && !read_not_write; // [R15]
    next_addr_s1 = cycle_load_n ? addr_s1 : addr;    // [R4]
    next_rd_s2   = rd_s1;
    next_rd_s3   = rd_s2;
    next_wr_s2   = wr_s1;
    next_waddr_s2 = addr_s1;
    // array read one cycle after the command, after any earlier commit
    next_w0_s2   = rd_s1 ? arr0[addr_s1] : w0_s2;
    next_w1_s2   = rd_s1 ? arr1[addr_s1] : w1_s2;
    next_w0_s3   = w0_s2;
    next_w1_s3   = w1_s2;
    // first write word and its lanes ride the true edge after the command
    next_wd0     = wr_s1 ? dq_in : wd0;                     // [R11]
    next_bws0    = wr_s1 ? byte_lane_select_n : bws0;       // [R16]
    if (pll_on) begin
      // 2.5-cycle mode: second word on the true edge of cycle t+3 [R9]
      next_q_pos   = rd_s3 ? w1_s3 : q_pos;                 // [R12]
      next_oe_pos  = rd_s3;                                 // [R17]
      next_vld_pos = rd_s2 || rd_s3;                        // [R18]
    end else begin
      // legacy mode: first word on the true edge of cycle t+1 [R7] [R10]
      next_q_pos   = rd_s1 ? arr0[addr_s1] : q_pos;         // [R12]
      next_oe_pos  = rd_s1;                                 // [R17]
      next_vld_pos = rd_s1;                                 // [R18]
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pll_s1   <= 1'b1;
      pll_on   <= 1'b1;
      phase_p  <= 1'b0;
      rd_s1    <= 1'b0;
      rd_s2    <= 1'b0;
      rd_s3    <= 1'b0;
      wr_s1    <= 1'b0;
      wr_s2    <= 1'b0;
      addr_s1  <= '0;
      waddr_s2 <= '0;
      w0_s2    <= DBSI_WORD_RESET;
      w1_s2    <= DBSI_WORD_RESET;
      w0_s3    <= DBSI_WORD_RESET;
      w1_s3    <= DBSI_WORD_RESET;
      wd0      <= DBSI_WORD_RESET;
      bws0     <= DBSI_LANES_OFF;
      q_pos    <= DBSI_WORD_RESET;
      oe_pos   <= 1'b0;
      vld_pos  <= 1'b0;
      space_ff <= 1'b0;
    end else begin
      // the mode pin is static; a change during a read tears that burst
      pll_s1   <= pll_disable_n;
      pll_on   <= pll_s1;
      phase_p  <= ~phase_n;                                 // [R6]
      rd_s1    <= next_rd_s1;
      rd_s2    <= next_rd_s2;
      rd_s3    <= next_rd_s3;
      wr_s1    <= next_wr_s1;
      wr_s2    <= next_wr_s2;
      addr_s1  <= next_addr_s1;
      waddr_s2 <= next_waddr_s2;
      w0_s2    <= next_w0_s2;
      w1_s2    <= next_w1_s2;
      w0_s3    <= next_w0_s3;
      w1_s3    <= next_w1_s3;
      wd0      <= next_wd0;
      bws0     <= next_bws0;
      q_pos    <= next_q_pos;
      oe_pos   <= next_oe_pos;
      vld_pos  <= next_vld_pos;
      space_ff <= fifo_ready;
    end
  end

  // complementary edge: second write word, and the read words that
  // belong to this half of the cycle
  always_comb begin
    if (pll_on) begin
      next_q_neg   = rd_s3 ? w0_s3 : q_neg;                 // [R5] [R9]
      next_oe_neg  = rd_s3;                                 // [R17]
      next_vld_neg = rd_s3;                                 // [R1] [R18]
    end else begin
      next_q_neg   = rd_s2 ? w1_s2 : q_neg;                 // [R5] [R10]
      next_oe_neg  = rd_s2;                                 // [R17]
      next_vld_neg = rd_s1 || rd_s2;                        // [R1] [R18]
    end
  end

  always_ff @(negedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      phase_n <= 1'b0;
      q_neg   <= DBSI_WORD_RESET;
      oe_neg  <= 1'b0;
      vld_neg <= 1'b0;
      commit  <= 1'b0;
      c_addr  <= '0;
      c_w0    <= DBSI_WORD_RESET;
      c_w1    <= DBSI_WORD_RESET;
      c_l0    <= DBSI_LANES_OFF;
      c_l1    <= DBSI_LANES_OFF;
    end else begin
      phase_n <= phase_p;                                   // [R6]
      q_neg   <= next_q_neg;
      oe_neg  <= next_oe_neg;
      vld_neg <= next_vld_neg;
      commit  <= wr_s2;
      if (wr_s2) begin
        c_addr <= waddr_s2;
        c_w0   <= wd0;
        c_w1   <= dq_in;                                    // [R11]
        c_l0   <= bws0;
        c_l1   <= byte_lane_select_n;                       // [R16]
      end
    end
  end

  // both words land in the array together on the second data edge
  always_ff @(negedge link_clk) begin
    if (link_rst_n && wr_s2) begin
      arr0[waddr_s2] <= lane_merge(arr0[waddr_s2], wd0, bws0);        // [R16]
      arr1[waddr_s2] <= lane_merge(arr1[waddr_s2], dq_in,
                                   byte_lane_select_n);                // [R16]
    end
  end

  // data, enable and valid follow the half of the cycle the echo strobe
  // is in, so all three switch on the echo strobe edges
  always_comb begin
    echo_strobe_true  = phase_p ^ phase_n;                  // [R6]
    echo_strobe_comp  = ~(phase_p ^ phase_n);               // [R6]
    dq_out            = (phase_p ^ phase_n) ? q_pos : q_neg;   // [R12]
    dq_oe             = (phase_p ^ phase_n) ? oe_pos : oe_neg; // [R17]
    read_output_valid = (phase_p ^ phase_n) ? vld_pos : vld_neg; // [R2]
    dq_out_word_valid_unused_n = ~dq_oe;
    wlog_space        = space_ff;
  end

  // write log toward the system clock; a log record is dropped when the
  // fifo is full, since the sram link itself can never be stalled
  assign fifo_in = {c_addr, c_w0, c_w1, c_l0, c_l1};
  // commit spans exactly one true rise per write and the record is stable
  // there, so back-to-back writes each push their own record

  dbsi_fifo #(
    .WIDTH (DBSI_LOG_W),
    .DEPTH (DBSI_FIFO_DEPTH)
  ) u_log_fifo (
    .wr_clk   (link_clk),
    .wr_rst_n (link_rst_n),
    .wr_valid (commit),
    .wr_ready (fifo_ready),
    .wr_data  (fifo_in),
    .rd_clk   (clk),
    .rd_rst_n (resetn),
    .rd_valid (fifo_valid),
    .rd_ready (!wlog_valid || wlog_ready),
    .rd_data  (fifo_out)
  );

  logic next_wlog_valid;

  always_comb begin
    next_wlog_valid = fifo_valid || (wlog_valid && !wlog_ready);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wlog_valid    <= 1'b0;
      wlog_addr     <= '0;
      wlog_word0    <= DBSI_WORD_RESET;
      wlog_word1    <= DBSI_WORD_RESET;
      wlog_lanes_n0 <= DBSI_LANES_OFF;
      wlog_lanes_n1 <= DBSI_LANES_OFF;
    end else begin
      wlog_valid <= next_wlog_valid;
      if (fifo_valid && (!wlog_valid || wlog_ready)) begin
        {wlog_addr, wlog_word0, wlog_word1, wlog_lanes_n0, wlog_lanes_n1}
          <= fifo_out;
      end
    end
  end

endmodule
`default_nettype wire

// ==== dbsi_core_chk.sv ====
// assertion checker on the burst sram core ports
`timescale 1ns/1ps
`default_nettype none
module dbsi_core_chk
  import dbsi_pkg::*;
(
  input wire logic          clk,
  input wire logic          resetn,
  input wire logic          link_clk,
  input wire logic          cycle_load_n,
  input wire logic          read_not_write,
  input wire logic          pll_disable_n,
  input wire logic          dq_oe,
  input wire logic          dq_out_word_valid_unused_n,
  input wire logic          read_output_valid,
  input wire logic          echo_strobe_true,
  input wire logic          echo_strobe_comp,
  input wire logic          wlog_valid,
  input wire logic          wlog_ready,
  input wire dbsi_addr_type wlog_addr,
  input wire dbsi_word_type wlog_word0
);
  logic [2:0] rises;
  logic [2:0] next_rises;
  logic       rd_cmd;
  assign rd_cmd = !cycle_load_n && read_not_write;
  // echo strobes only start after the link reset synchroniser lets go
  always_comb begin
    next_rises = (rises == 3'h7) ? rises : rises + 3'h1;
  end
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) rises <= 3'h0;
    else rises <= next_rises;
  end
  AST_ECHO_PAIR: assert property (@(posedge clk) disable iff (!resetn)
    echo_strobe_comp == !echo_strobe_true) else $error("echo pair broken");
  AST_ECHO_HIGH: assert property (@(negedge link_clk) disable iff (!resetn)
    rises == 3'h7 |-> echo_strobe_true) else $error("echo low in high phase");
  AST_ECHO_LOW: assert property (@(posedge link_clk) disable iff (!resetn)
    rises == 3'h7 |-> !echo_strobe_true) else $error("echo high in low phase");
  AST_OE_VALID: assert property (@(posedge clk) disable iff (!resetn)
    dq_oe |-> read_output_valid) else $error("data driven without valid");
  AST_OE_SPARE: assert property (@(posedge clk) disable iff (!resetn)
    dq_out_word_valid_unused_n == !dq_oe) else $error("spare level wrong");
  AST_LAT_ON: assert property (@(posedge link_clk)
    disable iff (!resetn)
    rd_cmd && pll_disable_n |-> ##3 (read_output_valid && dq_oe))
    else $error("pll-on read latency wrong");
  AST_LAT_OFF: assert property (@(posedge link_clk) disable iff (!resetn)
    rd_cmd && !pll_disable_n |-> ##1 read_output_valid ##1 dq_oe)
    else $error("legacy read latency wrong");
  AST_IDLE_FLOAT: assert property (@(posedge link_clk) disable iff (!resetn)
    !rd_cmd [*4] |-> !dq_oe && !read_output_valid)
    else $error("bus driven with no read");
  AST_LOG_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    wlog_valid && !wlog_ready |=> wlog_valid && $stable(wlog_addr)
    && $stable(wlog_word0)) else $error("log record changed while held");
  COV_READ_ON: cover property (@(posedge link_clk) rd_cmd && pll_disable_n);
  COV_READ_OFF: cover property (@(posedge link_clk) rd_cmd && !pll_disable_n);
  COV_LOG_STALL: cover property (@(posedge clk) wlog_valid && !wlog_ready);
endmodule
bind dbsi_core dbsi_core_chk chk_u (.clk(clk), .resetn(resetn),
  .link_clk(link_clk), .cycle_load_n(cycle_load_n),
  .read_not_write(read_not_write), .pll_disable_n(pll_disable_n),
  .dq_oe(dq_oe), .dq_out_word_valid_unused_n(dq_out_word_valid_unused_n),
  .read_output_valid(read_output_valid), .echo_strobe_true(echo_strobe_true),
  .echo_strobe_comp(echo_strobe_comp), .wlog_valid(wlog_valid),
  .wlog_ready(wlog_ready), .wlog_addr(wlog_addr), .wlog_word0(wlog_word0));
`default_nettype wire

// ==== dbsi_ctrl_model.sv ====
// memory controller model issuing bursts on the link clock
`timescale 1ns/1ps
`default_nettype none
module dbsi_ctrl_model
  import dbsi_pkg::*;
(
  input  wire logic     link_clk,
  output logic          cycle_load_n,
  output logic          read_not_write,
  output dbsi_addr_type addr,
  output dbsi_lane_type byte_lane_select_n,
  output dbsi_word_type dq_in
);
  initial begin
    cycle_load_n = 1'b1;
    read_not_write = 1'b0;
    addr = '0;
    byte_lane_select_n = DBSI_LANES_OFF;
    dq_in = '0;
  end
  // idle: stale qualifiers are flipped so nothing is reused by luck
  task automatic nop();
    #1;
    cycle_load_n = 1'b1;
    addr = ~addr;
    read_not_write = ~read_not_write;
    @(posedge link_clk);
  endtask
  // set up just after one rise, taken at the next rise
  task automatic cmd(input logic rd, input dbsi_addr_type a,
                     input dbsi_word_type d0, d1,
                     input dbsi_lane_type l0, l1);
    #1;
    cycle_load_n = 1'b0;
    read_not_write = rd;
    addr = a;
    dq_in = d0;
    byte_lane_select_n = l0;
    @(posedge link_clk);
    if (!rd) begin
      nop();
      #1;
      dq_in = d1;
      byte_lane_select_n = l1;
      @(negedge link_clk);
      #1;
      dq_in = ~d1;
      byte_lane_select_n = ~l1;
      @(posedge link_clk);
    end
  endtask
endmodule
`default_nettype wire

// ==== ddr_burst_sram_interface_test.sv ====
// self-checking bench for the burst sram core
`timescale 1ns/1ps
`default_nettype none
module ddr_burst_sram_interface_test
  import dbsi_pkg::*;
;
  logic          clk, link_clk, resetn, pll_disable_n, wlog_ready, stall;
  logic          load_n, rnw, oe, oe_n, valid, echo_t, echo_c, space, lv;
  logic          full;
  dbsi_addr_type addr, la;
  dbsi_lane_type lanes_n, ll0, ll1;
  dbsi_word_type dq_in, dq_out, lw0, lw1;
  dbsi_word_type mem0 [DBSI_DEPTH];
  dbsi_word_type mem1 [DBSI_DEPTH];
  dbsi_word_type rq [$];
  logic [DBSI_LOG_W-1:0] lq [$];
  int            num_errors = 0, compares = 0, seed = 97186, cycles = 0;

  dbsi_ctrl_model ctl_u (.link_clk(link_clk), .cycle_load_n(load_n),
    .read_not_write(rnw), .addr(addr), .byte_lane_select_n(lanes_n),
    .dq_in(dq_in));
  dbsi_core dut_u (.clk(clk), .resetn(resetn), .link_clk(link_clk),
    .cycle_load_n(load_n), .read_not_write(rnw), .addr(addr),
    .byte_lane_select_n(lanes_n), .dq_in(dq_in),
    .dq_out_word_valid_unused_n(oe_n), .dq_out(dq_out), .dq_oe(oe),
    .read_output_valid(valid), .echo_strobe_true(echo_t),
    .echo_strobe_comp(echo_c), .pll_disable_n(pll_disable_n),
    .wlog_space(space), .wlog_valid(lv), .wlog_ready(wlog_ready),
    .wlog_addr(la), .wlog_word0(lw0), .wlog_word1(lw1),
    .wlog_lanes_n0(ll0), .wlog_lanes_n1(ll1));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // far below the legacy-mode ceiling, phase offset from clk
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #24 link_clk = ~link_clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic dbsi_word_type merge(dbsi_word_type o, dbsi_word_type n,
                                          dbsi_lane_type sel_n);
    merge = o;
    for (int i = 0; i < DBSI_LANES; i++)
      if (!sel_n[i]) merge[i*DBSI_LANE_W +: DBSI_LANE_W] =
        n[i*DBSI_LANE_W +: DBSI_LANE_W];
  endfunction
  task automatic wr(input dbsi_addr_type a, input dbsi_lane_type l0, l1);
    dbsi_word_type d0, d1;
    d0 = dbsi_word_type'($random(seed));
    d1 = dbsi_word_type'($random(seed));
    mem0[a] = merge(mem0[a], d0, l0);
    mem1[a] = merge(mem1[a], d1, l1);
    lq.push_back({a, d0, d1, l0, l1});
    ctl_u.cmd(1'b0, a, d0, d1, l0, l1);
  endtask
  task automatic rd(input dbsi_addr_type a);
    rq.push_back(mem0[a]);
    rq.push_back(mem1[a]);
    ctl_u.cmd(1'b1, a, '0, '0, '0, '0);
  endtask

  always @(negedge clk) begin
    wlog_ready <= stall ? 1'b0 : 1'($random(seed));
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // each driven half cycle is sampled mid-phase, clear of both edges
  always @(link_clk) begin
    #12;
    if (oe === 1'b1) begin
      chk(valid, 1'b1);
      chk(rq.size() > 0, 1'b1);
      if (rq.size() > 0) chk(dq_out, rq.pop_front());
    end
  end
  always @(posedge clk)
    if (lv === 1'b1 && wlog_ready === 1'b1) begin
      chk(lq.size() > 0, 1'b1);
      if (lq.size() > 0) chk({la, lw0, lw1, ll0, ll1}, lq.pop_front());
    end

  initial begin
    dbsi_addr_type wa;
    resetn = 1'b0;
    pll_disable_n = 1'b1;
    wlog_ready = 1'b0;
    stall = 1'b0;
    // link side needs three of its own periods in reset
    repeat (40) @(negedge clk);
    chk({oe, valid, echo_t, echo_c, lv}, 5'h02);
    resetn = 1'b1;
    repeat (4) @(posedge link_clk);
    for (int a = 0; a < DBSI_DEPTH; a++) wr(4'(a), 2'h0, 2'h0);
    for (int k = 0; k < 8; k++) begin
      wa = 4'($random(seed));
      wr(wa, k[1:0], ~k[1:0]);
      rd(wa);
      rd(wa + 4'h1);
      ctl_u.nop();
      ctl_u.nop();
    end
    stall = 1'b1;
    full = 1'b0;
    for (int k = 0; k < 8 && !full; k++) begin
      ctl_u.nop();
      ctl_u.nop();
      #1;
      if (space === 1'b1) wr(4'(k), 2'h3, 2'h3);
      else full = 1'b1;
    end
    chk(full, 1'b1);
    stall = 1'b0;
    @(negedge clk) pll_disable_n = 1'b0;
    repeat (6) @(posedge link_clk);
    wr(4'h5, 2'h0, 2'h2);
    rd(4'h5);
    rd(4'hA);
    ctl_u.nop();
    repeat (12) @(posedge link_clk);
    chk(64'(rq.size()), 64'h0);
    chk(64'(lq.size()), 64'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
